// ==== rtl/radio_timer_pkg.sv ====
package radio_timer_pkg;

	// ------------------------------------------------------------
	// Register byte addresses
	// ------------------------------------------------------------
	localparam logic [31:0] ADDR_PREFETCH = 32'h400000f0;
	localparam logic [31:0] ADDR_COARSE = 32'h400000f4;
	localparam logic [31:0] ADDR_PRECISE = 32'h400000f8;
	localparam logic [31:0] ADDR_SAMPLE = 32'h400000fc;
	localparam logic [31:0] ADDR_CTRL2 = 32'h40000200;
	localparam logic [31:0] ADDR_SAMPLED = 32'h40000210;
	localparam logic [31:0] ADDR_IRQ_STAT = 32'h40000214;
	localparam logic [31:0] ADDR_IRQ_MASK = 32'h40000218;

	// ------------------------------------------------------------
	// Field positions of core_control_two
	// ------------------------------------------------------------
	localparam int CTL_RSSI_SEL = 21;
	localparam int CTL_WAKE_STAT = 20;
	localparam int CTL_RSV_A = 19;
	localparam int CTL_RSV_B = 18;
	localparam int CTL_RSV_C = 17;
	localparam int CTL_MHZ_LSB = 9;
	localparam int CTL_PERMIT = 8;
	localparam int CTL_MON = 7;
	localparam int CTL_CLK_STAT = 6;
	localparam int CTL_REVERSE = 5;
	localparam int CTL_SRC_LSB = 3;
	localparam int SAMPLE_BIT = 0;

	// Interrupt status and mask bit positions
	localparam int IRQ_COARSE = 0;
	localparam int IRQ_PRECISE = 1;
	localparam int IRQ_WAKEUP = 2;
	localparam int IRQ_SLEEP_EXIT = 3;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_PS = 4000;
	localparam int TICK_PERIOD_US = 625;
	localparam int TICK_CYCLES = (TICK_PERIOD_US * 1000000) / CLK_PERIOD_PS;
	localparam logic [1:0] WAKE_ACK_EDGES = 2'h2;
	localparam logic [31:0] RESET_WORD = 32'h00000000;

	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	typedef enum logic [1:0] {SLP_IDLE, SLP_WAIT1, SLP_WAIT2, SLP_DOWN} sleep_e;

	typedef struct packed {
		logic [7:0] p0;
		logic [3:0] p1;
	} debug_pins_s;

	typedef struct packed {
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic [7:0] prefetch;
		logic [15:0] coarse;
		logic [26:0] precise;
		logic capture;
		logic [26:0] sampled;
		logic [26:0] base;
		logic [17:0] div;
		logic rssi_sel;
		logic wake_stat;
		logic [1:0] wake_cnt;
		logic rsv_a;
		logic rsv_b;
		logic rsv_c;
		logic [5:0] mhz;
		logic permit;
		logic mon;
		logic clk_stat;
		logic rev;
		logic [1:0] src;
		logic [3:0] irq_stat;
		logic [3:0] irq_mask;
		logic irq;
		logic lp_prev;
		logic req_prev;
		sleep_e slp;
		logic [7:0] rssi;
		debug_pins_s pins;
	} state_s;

endpackage : radio_timer_pkg

// ==== rtl/radio_core_timer_control.sv ====
`timescale 1ns/10ps
// Notes on behaviour
// - Software-writable 8-bit prefetch instant in microseconds.
// - Coarse interrupt when target equals counter bits 19:4 and bits 3:0 zero.
// - Precise interrupt when 27-bit target equals whole base counter.
// - Writing one to capture bit samples counter, then bit self-clears.
// - Control bit 21 picks peak-hold (0) or averaged (1) strength.
// - Bit 20 shows pending wakeup; cleared after radio up plus two slow clock rising edges.
// - Bits 14:9 hold master clock frequency in MHz.
// - After deep sleep request, slow-clock sequence sets power-down permission bit 8.
// - Permission clears on sleep exit, together with sleep-exit interrupt.
// - Bit 7 set on each slow clock rising edge; software only clears.
// - Edge monitor does not set while timer held in reset.
// - Bit 6 reads 0 on slow clock, 1 on master clock.
// - Reverse clear: bus bit n to port0 pin n, bits 3:0 to port1.
// - Reverse set: bus bit n to port0 pin 7-n, port1 carries bits 4..7.
// - Bits 4:3 choose which 8-bit debug source feeds the bus.
module radio_core_timer_control
	import radio_timer_pkg::*;
#(
	parameter int TICK_LEN = TICK_CYCLES
) (
	input wire logic MCLK_IN,
	input wire logic RSTN_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [31:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic LPCLK_IN,
	input wire logic TIMER_LP_RESET_IN,
	input wire logic DEEP_SLEEP_REQ_IN,
	input wire logic SLEEP_EXIT_IN,
	input wire logic LP_WAKEUP_IN,
	input wire logic RADIO_UP_IN,
	input wire logic CLK_IS_MASTER_IN,
	input wire logic [7:0] RSSI_PEAK_IN,
	input wire logic [7:0] RSSI_AVG_IN,
	input wire logic [3:0][7:0] DEBUG_SRC_IN,
	output logic [7:0] RSSI_OUT,
	output logic [7:0] PREFETCH_INSTANT_OUT,
	output logic [5:0] MASTER_CLOCK_MHZ_OUT,
	output logic POWERDOWN_PERMITTED_OUT,
	output logic [7:0] DEBUG_P0_OUT,
	output logic [3:0] DEBUG_P1_OUT,
	output logic IRQ_OUT
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	state_s s_r;
	state_s s_nxt;
	logic [7:0] debug_bus;
	logic [7:0] debug_rev;
	logic lp_edge;
	logic tick;
	logic [26:0] base_inc;
	logic coarse_hit;
	logic precise_hit;
	logic access;
	logic wr;
	logic [31:0] ctrl2_word;

	// ------------------------------------------------------------
	// Debug bus routing
	// ------------------------------------------------------------
	// source select
	assign debug_bus = DEBUG_SRC_IN[s_r.src];

	genvar gi;
	generate
		for (gi = 0; gi < 8; gi++) begin : g_rev
			assign debug_rev[gi] = debug_bus[7 - gi];
		end
	endgenerate

	// ------------------------------------------------------------
	// Slow clock and base timer
	// ------------------------------------------------------------
	// Slow clock taken as data: an edge lasts one master cycle
	assign lp_edge = LPCLK_IN & ~s_r.lp_prev;
	assign tick = ~TIMER_LP_RESET_IN && (s_r.div == 18'(TICK_LEN - 1));
	assign base_inc = s_r.base + 27'h1;
	assign coarse_hit = tick && (base_inc[19:4] == s_r.coarse) && (base_inc[3:0] == 4'h0);
	assign precise_hit = tick && (base_inc == s_r.precise);

	// ------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------
	// Qualified by own ready, so a stuck enable cannot write twice
	assign access = PSEL_IN & PENABLE_IN & s_r.pready;
	assign wr = access & PWRITE_IN;

	// ------------------------------------------------------------
	// Control word readback
	// ------------------------------------------------------------
	assign ctrl2_word = {10'h000, s_r.rssi_sel, s_r.wake_stat, s_r.rsv_a, s_r.rsv_b,
		s_r.rsv_c, 2'h0, s_r.mhz, s_r.permit, s_r.mon, s_r.clk_stat, s_r.rev,
		s_r.src, 3'h0};

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.lp_prev = LPCLK_IN;
		s_nxt.req_prev = DEEP_SLEEP_REQ_IN;
		s_nxt.pready = 1'b0;
		s_nxt.pslverr = 1'b0;

		// Zero wait states: answer is prepared in the setup cycle
		if (PSEL_IN && !PENABLE_IN) begin
			s_nxt.pready = 1'b1;
			s_nxt.pslverr = 1'b0;
			s_nxt.prdata = RESET_WORD;
			unique case (PADDR_IN)
				ADDR_PREFETCH: s_nxt.prdata = {24'h000000, s_r.prefetch};
				ADDR_COARSE: s_nxt.prdata = {16'h0000, s_r.coarse};
				ADDR_PRECISE: s_nxt.prdata = {5'h00, s_r.precise};
				ADDR_SAMPLE: s_nxt.prdata = {31'h00000000, s_r.capture};
				ADDR_CTRL2: s_nxt.prdata = ctrl2_word;
				ADDR_SAMPLED: s_nxt.prdata = {5'h00, s_r.sampled};
				ADDR_IRQ_STAT: s_nxt.prdata = {28'h0000000, s_r.irq_stat};
				ADDR_IRQ_MASK: s_nxt.prdata = {28'h0000000, s_r.irq_mask};
				default: s_nxt.pslverr = 1'b1;
			endcase
		end

		// Base time counter, held at zero while the timer is in reset
		if (TIMER_LP_RESET_IN) begin
			s_nxt.div = 18'h00000;
			s_nxt.base = 27'h0000000;
		end else if (tick) begin
			s_nxt.div = 18'h00000;
			s_nxt.base = base_inc;
		end else begin
			s_nxt.div = s_r.div + 18'h00001;
		end

		if (s_r.capture) begin
			s_nxt.sampled = s_r.base;
			s_nxt.capture = 1'b0;
		end

		if (wr) begin
			unique case (PADDR_IN)
				ADDR_PREFETCH: s_nxt.prefetch = PWDATA_IN[7:0];
				ADDR_COARSE: s_nxt.coarse = PWDATA_IN[15:0];
				ADDR_PRECISE: s_nxt.precise = PWDATA_IN[26:0];
				ADDR_SAMPLE: s_nxt.capture = PWDATA_IN[SAMPLE_BIT];
				ADDR_CTRL2: begin
					s_nxt.rssi_sel = PWDATA_IN[CTL_RSSI_SEL];
					s_nxt.rsv_a = PWDATA_IN[CTL_RSV_A];
					s_nxt.rsv_b = PWDATA_IN[CTL_RSV_B];
					s_nxt.rsv_c = PWDATA_IN[CTL_RSV_C];
					s_nxt.mhz = PWDATA_IN[CTL_MHZ_LSB +: 6];
					s_nxt.rev = PWDATA_IN[CTL_REVERSE];
					s_nxt.src = PWDATA_IN[CTL_SRC_LSB +: 2];
					if (!PWDATA_IN[CTL_MON]) begin
						s_nxt.mon = 1'b0;
					end
				end
				ADDR_IRQ_STAT: s_nxt.irq_stat = s_r.irq_stat & ~PWDATA_IN[3:0];
				ADDR_IRQ_MASK: s_nxt.irq_mask = PWDATA_IN[3:0];
				default: ;
			endcase
		end

		if (lp_edge && !TIMER_LP_RESET_IN) begin
			s_nxt.mon = 1'b1;
		end

		// Hardware event wins over a same-cycle W1C clear
		// one event per matching tick
		if (coarse_hit) begin
			s_nxt.irq_stat[IRQ_COARSE] = 1'b1;
		end
		if (precise_hit) begin
			s_nxt.irq_stat[IRQ_PRECISE] = 1'b1;
		end

		if (s_r.wake_stat && RADIO_UP_IN && lp_edge) begin
			s_nxt.wake_cnt = s_r.wake_cnt + 2'h1;
			if (s_nxt.wake_cnt == WAKE_ACK_EDGES) begin
				s_nxt.wake_stat = 1'b0;
			end
		end
		if (LP_WAKEUP_IN) begin
			s_nxt.wake_stat = 1'b1;
			s_nxt.wake_cnt = 2'h0;
			s_nxt.irq_stat[IRQ_WAKEUP] = 1'b1;
		end

		unique case (s_r.slp)
			SLP_IDLE: begin
				if (DEEP_SLEEP_REQ_IN && !s_r.req_prev) begin
					s_nxt.slp = SLP_WAIT1;
				end
			end
			SLP_WAIT1: begin
				if (lp_edge) begin
					s_nxt.slp = SLP_WAIT2;
				end
			end
			SLP_WAIT2: begin
				if (lp_edge) begin
					s_nxt.slp = SLP_DOWN;
					s_nxt.permit = 1'b1;
				end
			end
			SLP_DOWN: ;
		endcase

		if (SLEEP_EXIT_IN && s_r.slp != SLP_IDLE) begin
			s_nxt.slp = SLP_IDLE;
			s_nxt.permit = 1'b0;
			s_nxt.irq_stat[IRQ_SLEEP_EXIT] = 1'b1;
		end

		s_nxt.clk_stat = CLK_IS_MASTER_IN;
		s_nxt.rssi = s_r.rssi_sel ? RSSI_AVG_IN : RSSI_PEAK_IN;

		// port one follows port zero low nibble
		s_nxt.pins.p0 = s_r.rev ? debug_rev : debug_bus;
		s_nxt.pins.p1 = s_nxt.pins.p0[3:0];

		// Level output registered from the next status and mask
		s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
	end

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign PRDATA_OUT = s_r.prdata;
	assign PREADY_OUT = s_r.pready;
	assign PSLVERR_OUT = s_r.pslverr;
	assign RSSI_OUT = s_r.rssi;
	assign PREFETCH_INSTANT_OUT = s_r.prefetch;
	assign MASTER_CLOCK_MHZ_OUT = s_r.mhz;
	assign POWERDOWN_PERMITTED_OUT = s_r.permit;
	assign DEBUG_P0_OUT = s_r.pins.p0;
	assign DEBUG_P1_OUT = s_r.pins.p1;
	assign IRQ_OUT = s_r.irq;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge MCLK_IN); endclocking
	default disable iff (!RSTN_IN);
	// RSTN_IN guards skip the release edge, where outputs are still cleared

	a_prefetch_write: assert property (
		wr && PADDR_IN == ADDR_PREFETCH |=> PREFETCH_INSTANT_OUT == $past(PWDATA_IN[7:0]))
		else $error("prefetch instant not stored");

	a_coarse_match: assert property (
		$rose(s_r.irq_stat[IRQ_COARSE]) |-> $past(coarse_hit))
		else $error("coarse event without match");

	a_precise_match: assert property (
		precise_hit |=> s_r.irq_stat[IRQ_PRECISE] && s_r.base == s_r.precise)
		else $error("precise event missing");

	a_capture_clear: assert property (
		s_r.capture |=> !s_r.capture && s_r.sampled == $past(s_r.base))
		else $error("capture not taken");

	a_rssi_source: assert property (
		RSTN_IN |=> RSSI_OUT ==
			($past(s_r.rssi_sel) ? $past(RSSI_AVG_IN) : $past(RSSI_PEAK_IN)))
		else $error("wrong strength source");

	a_wake_ack: assert property (
		$fell(s_r.wake_stat) |-> $past(RADIO_UP_IN && lp_edge && s_r.wake_cnt == 2'h1))
		else $error("wakeup cleared early");

	a_mhz_field: assert property (
		wr && PADDR_IN == ADDR_CTRL2 |=> MASTER_CLOCK_MHZ_OUT == $past(PWDATA_IN[14:9]))
		else $error("frequency field not stored");

	a_permit_set: assert property (
		$rose(POWERDOWN_PERMITTED_OUT) |-> $past(s_r.slp == SLP_WAIT2 && lp_edge))
		else $error("permission set out of sequence");

	a_permit_clear: assert property (
		$fell(POWERDOWN_PERMITTED_OUT) |-> s_r.irq_stat[IRQ_SLEEP_EXIT])
		else $error("permission cleared without exit event");

	a_monitor_set: assert property (
		lp_edge && !TIMER_LP_RESET_IN |=> s_r.mon)
		else $error("monitor missed an edge");

	a_monitor_reset: assert property (
		$rose(s_r.mon) |-> $past(lp_edge && !TIMER_LP_RESET_IN))
		else $error("monitor set during timer reset");

	a_clock_status: assert property (
		RSTN_IN |=> s_r.clk_stat == $past(CLK_IS_MASTER_IN))
		else $error("clock status stale");

	a_port_order: assert property (
		RSTN_IN && !s_r.rev |=> DEBUG_P0_OUT == $past(debug_bus) &&
			DEBUG_P1_OUT == $past(debug_bus[3:0]))
		else $error("straight routing wrong");

	a_port_reverse: assert property (
		RSTN_IN && s_r.rev |=> DEBUG_P0_OUT[0] == $past(debug_bus[7]) &&
			DEBUG_P0_OUT[7] == $past(debug_bus[0]) &&
			DEBUG_P1_OUT[3] == $past(debug_bus[4]))
		else $error("reversed routing wrong");

	a_single_event: assert property (
		tick |=> !tick [*3])
		else $error("ticks too close");

	a_coarse_raise: assert property (
		coarse_hit |=> s_r.irq_stat[IRQ_COARSE])
		else $error("coarse event missing");

	a_precise_once: assert property (
		$rose(s_r.irq_stat[IRQ_PRECISE]) |-> $past(precise_hit))
		else $error("precise event without match");

	a_capture_start: assert property (
		wr && PADDR_IN == ADDR_SAMPLE && PWDATA_IN[SAMPLE_BIT] |=> s_r.capture)
		else $error("capture request lost");

	a_prefetch_hold: assert property (
		!(wr && PADDR_IN == ADDR_PREFETCH) |=> $stable(PREFETCH_INSTANT_OUT))
		else $error("prefetch instant changed without write");

	a_mhz_hold: assert property (
		!(wr && PADDR_IN == ADDR_CTRL2) |=> $stable(MASTER_CLOCK_MHZ_OUT))
		else $error("frequency field changed without write");

	a_wake_pending: assert property (
		LP_WAKEUP_IN |=> s_r.wake_stat && s_r.irq_stat[IRQ_WAKEUP])
		else $error("wakeup not recorded");

	a_permit_hold: assert property (
		!POWERDOWN_PERMITTED_OUT && s_r.slp != SLP_WAIT2 |=> !POWERDOWN_PERMITTED_OUT)
		else $error("permission raised outside last step");

	a_exit_clear: assert property (
		SLEEP_EXIT_IN && s_r.slp != SLP_IDLE |=>
			!POWERDOWN_PERMITTED_OUT && s_r.slp == SLP_IDLE)
		else $error("sleep exit left permission set");

	a_monitor_hold: assert property (
		TIMER_LP_RESET_IN && !s_r.mon |=> !s_r.mon)
		else $error("monitor rose while timer held");

	a_source_select: assert property (
		RSTN_IN && !s_r.rev |=> DEBUG_P0_OUT == $past(DEBUG_SRC_IN[s_r.src]))
		else $error("debug source not selected");

endmodule : radio_core_timer_control

// ==== dv/radio_core_timer_control_tb.sv ====
`timescale 1ns/10ps
module radio_core_timer_control_tb;
	import radio_timer_pkg::*;
	localparam int TL = 20;
	logic mclk, rstn, psel, pen, pwr, lpclk, lprst, dsreq, sexit, wake, rup, cmast;
	logic [31:0] paddr, pwdata, prdata, rd, s;
	logic pready, pslverr, irq, permit, er;
	logic [7:0] rpk, ravg, rssi, pfo, p0, e;
	logic [3:0][7:0] dsrc;
	logic [5:0] mhz;
	logic [3:0] p1;
	int err_total, tests_run;

	radio_core_timer_control #(.TICK_LEN(TL)) radio_core_timer_control_inst (
		.MCLK_IN(mclk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .LPCLK_IN(lpclk),
		.TIMER_LP_RESET_IN(lprst), .DEEP_SLEEP_REQ_IN(dsreq), .SLEEP_EXIT_IN(sexit),
		.LP_WAKEUP_IN(wake), .RADIO_UP_IN(rup), .CLK_IS_MASTER_IN(cmast),
		.RSSI_PEAK_IN(rpk), .RSSI_AVG_IN(ravg), .DEBUG_SRC_IN(dsrc), .RSSI_OUT(rssi),
		.PREFETCH_INSTANT_OUT(pfo), .MASTER_CLOCK_MHZ_OUT(mhz),
		.POWERDOWN_PERMITTED_OUT(permit), .DEBUG_P0_OUT(p0), .DEBUG_P1_OUT(p1),
		.IRQ_OUT(irq)
	);

	initial begin
		mclk = 0;
		forever #2 mclk = ~mclk;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic finish_test();
		$display("Checks %0d, errors %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_total++;
			$display("[FAIL] %0t mismatch got %h exp %h", $time, got, exp);
		end
	endtask : chk

	// Bounded wait: a dead slave ends the run instead of hanging it
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		psel <= 1;
		pen <= 0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		pen <= 1;
		// Read before this edge's update lands, as the slave samples it
		do begin
			@(posedge mclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			err_total++;
			$display("[FAIL] %0t no ready", $time);
			finish_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		pen <= 0;
	endtask : apb

	task automatic rdc(input logic [31:0] a, input logic [31:0] m, input logic [31:0] x);
		apb(0, a, 32'h0);
		chk(rd & m, x);
	endtask : rdc

	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask : cyc

	task automatic lp_edge();
		cyc(4);
		lpclk <= 1;
		cyc(4);
		lpclk <= 0;
	endtask : lp_edge

	task automatic counter_capture();
		apb(1, ADDR_SAMPLE, 32'h1);
		apb(0, ADDR_SAMPLED, 32'h0);
	endtask : counter_capture

	task automatic wait_bit(input int b);
		int n;
		n = 0;
		do begin
			apb(0, ADDR_IRQ_STAT, 32'h0);
			n++;
		end while (rd[b] !== 1'b1 && n < 300);
		if (rd[b] !== 1'b1) begin
			err_total++;
			$display("[FAIL] %0t no event", $time);
			finish_test();
		end
	endtask : wait_bit

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_regs();
		rdc(ADDR_CTRL2, 32'hffffffff, 32'h0);
		rdc(ADDR_PREFETCH, 32'hffffffff, 32'h0);
		apb(1, ADDR_PREFETCH, 32'hffffffa5);
		rdc(ADDR_PREFETCH, 32'hffffffff, 32'ha5);
		chk(32'(pfo), 32'ha5);
		apb(1, ADDR_COARSE, 32'hffffffff);
		rdc(ADDR_COARSE, 32'hffffffff, 32'hffff);
		apb(1, ADDR_PRECISE, 32'hffffffff);
		rdc(ADDR_PRECISE, 32'hffffffff, 32'h07ffffff);
		apb(1, ADDR_CTRL2, 32'hffffff7f);
		rdc(ADDR_CTRL2, 32'hffffff7f, 32'h002e7e38);
		apb(0, 32'h40000204, 32'h0);
		chk(32'(er), 32'h1);
		chk(rd, 32'h0);
	endtask : t_regs

	task automatic t_fine();
		counter_capture();
		s = rd;
		apb(1, ADDR_PRECISE, s + 3);
		rdc(ADDR_SAMPLE, 32'hffffffff, 32'h0);
		rdc(ADDR_IRQ_STAT, 32'hffffffff, 32'h0);
		wait_bit(IRQ_PRECISE);
		chk(rd, 32'h2);
		chk(32'(irq), 32'h0);
		counter_capture();
		chk(rd, s + 3);
		apb(1, ADDR_IRQ_MASK, 32'h2);
		cyc(2);
		chk(32'(irq), 32'h1);
		apb(1, ADDR_IRQ_STAT, 32'h2);
		cyc(2);
		chk(32'(irq), 32'h0);
		cyc(4 * TL);
		rdc(ADDR_IRQ_STAT, 32'hffffffff, 32'h0);
	endtask : t_fine

	task automatic t_coarse();
		counter_capture();
		// Two steps ahead: the target must not pass before it is written
		s = (rd >> 4) + 2;
		apb(1, ADDR_COARSE, s);
		rdc(ADDR_IRQ_STAT, 32'hffffffff, 32'h0);
		wait_bit(IRQ_COARSE);
		chk(rd, 32'h1);
		chk(32'(irq), 32'h0);
		counter_capture();
		chk(rd & 32'hfffff, s << 4);
		apb(1, ADDR_IRQ_STAT, 32'h1);
		rdc(ADDR_IRQ_STAT, 32'hffffffff, 32'h0);
	endtask : t_coarse

	task automatic t_ctrl();
		apb(1, ADDR_CTRL2, 32'h0);
		cyc(2);
		chk(32'(rssi), 32'h3c);
		apb(1, ADDR_CTRL2, 32'h00202000);
		cyc(2);
		chk(32'(rssi), 32'hc3);
		chk(32'(mhz), 32'h10);
		apb(1, ADDR_CTRL2, 32'h00001000);
		rdc(ADDR_CTRL2, 32'h00207e00, 32'h1000);
		chk(32'(mhz), 32'h8);
		cmast <= 1;
		rdc(ADDR_CTRL2, 32'h40, 32'h40);
		cmast <= 0;
		for (int i = 0; i < 8; i++) begin
			apb(1, ADDR_CTRL2, i << 3);
			cyc(2);
			e = dsrc[i % 4];
			if (i > 3) e = {<<{dsrc[i % 4]}};
			chk(32'(p0), 32'(e));
			chk(32'(p1), 32'(e[3:0]));
		end
	endtask : t_ctrl

	task automatic t_lowpower();
		lprst <= 1;
		lp_edge();
		rdc(ADDR_CTRL2, 32'h80, 32'h0);
		lprst <= 0;
		lp_edge();
		rdc(ADDR_CTRL2, 32'h80, 32'h80);
		apb(1, ADDR_CTRL2, 32'h0);
		rdc(ADDR_CTRL2, 32'h80, 32'h0);
		apb(1, ADDR_CTRL2, 32'h80);
		rdc(ADDR_CTRL2, 32'h80, 32'h0);
		wake <= 1;
		cyc(1);
		wake <= 0;
		rdc(ADDR_CTRL2, 32'h100000, 32'h100000);
		rdc(ADDR_IRQ_STAT, 32'h4, 32'h4);
		rup <= 1;
		lp_edge();
		rdc(ADDR_CTRL2, 32'h100000, 32'h100000);
		lp_edge();
		rdc(ADDR_CTRL2, 32'h100000, 32'h0);
		dsreq <= 1;
		lp_edge();
		rdc(ADDR_CTRL2, 32'h100, 32'h0);
		lp_edge();
		rdc(ADDR_CTRL2, 32'h100, 32'h100);
		chk(32'(permit), 32'h1);
		sexit <= 1;
		cyc(1);
		sexit <= 0;
		cyc(2);
		chk(32'(permit), 32'h0);
		rdc(ADDR_IRQ_STAT, 32'h8, 32'h8);
	endtask : t_lowpower

	initial begin
		{rstn, psel, pen, pwr, lpclk, lprst, dsreq, sexit, wake, rup, cmast} = '0;
		{paddr, pwdata} = '0;
		rpk = 8'h3c;
		ravg = 8'hc3;
		dsrc = {8'hc6, 8'h4b, 8'h2e, 8'h1d};
		err_total = 0;
		tests_run = 0;
		cyc(16);
		rstn <= 1;
		t_regs();
		t_fine();
		t_coarse();
		t_ctrl();
		t_lowpower();
		finish_test();
	end
endmodule : radio_core_timer_control_tb
